/* File: pm_regs_defines.vh */
// Offsets, field positions and codes of the power management register dword
`ifndef PM_REGS_DEFINES_VH
`define PM_REGS_DEFINES_VH
`define PM_DWORD_ADDR      8'hE0
`define PM_CTRL_OFFSET     8'hE0
`define PM_EXT_OFFSET      8'hE2
`define PM_DATA_OFFSET     8'hE3
`define PM_STATE_LSB       0
`define PM_STATE_MSB       1
`define PM_STATE_D0        2'h0
`define PM_STATE_D1        2'h1
`define PM_STATE_D2        2'h2
`define PM_STATE_D3        2'h3
`define PM_STATE_RESET     2'h0
`define PM_CLKSTOP_BIT     22
`define PM_BPCC_BIT        23
`define PM_RESET_PULSE_CYC 4'h4
`define PM_RSVLO_LSB       2
`define PM_RSVLO_MSB       7
`define PM_WAKE_EN_BIT     8
`define PM_DSEL_LSB        9
`define PM_DSEL_MSB        12
`define PM_DSCALE_LSB      13
`define PM_DSCALE_MSB      14
`define PM_WAKE_STAT_BIT   15
`define PM_RSVEXT_LSB      16
`define PM_RSVEXT_MSB      21
`define PM_DATA_LSB        24
`define PM_DATA_MSB        31
`define PM_RESERVED_VALUE  6'h00
`define PM_DSEL_VALUE      4'h0
`define PM_DSCALE_VALUE    2'h0
`define PM_DATA_VALUE      8'h00
`define PM_SYNC_RESET      3'h0
`define PM_STRAP_RESET     1'b0
`define PM_CLK_RUN_RESET   1'b1
`define PM_PULSE_RESET     1'b0
`define PM_READ_RESET      32'h0000_0000
`endif

/* File: pm_regs.v */
// Power management control/status, bridge extension and data register dword
// What this block does
// - Two-bit power state, D0 or D3, resets D0
// - Unimplemented state writes complete, change nothing
// - D3 to D0 write pulses internal chip reset
// - Wake enable and wake status read zero
// - Data select and scale fields read zero
// - Data byte reads as 00h always
// - Bit 23 follows the power/clock strap
// - Bit 22 reads one when bit 23 set
// - Strap high and D3hot stops secondary clocks
// - Low byte enables select fields in dword
// - Reserved fields read only, return zero
`include "pm_regs_defines.vh"

module pm_regs (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        cfgWrite,
  input  wire        cfgRead,
  input  wire [7:0]  cfgAddr,
  input  wire [3:0]  byteEnable_n,
  input  wire [31:0] cfgWriteData,
  input  wire        clockCtrlStrap,
  output reg  [31:0] cfgReadData,
  output reg         chipReset,
  output reg         secClockRun
);

  // ----------------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------------
  localparam [7:0]  DWORD_ADDR     = `PM_DWORD_ADDR;
  localparam [1:0]  STATE_D0       = `PM_STATE_D0;
  localparam [1:0]  STATE_D1       = `PM_STATE_D1;
  localparam [1:0]  STATE_D2       = `PM_STATE_D2;
  localparam [1:0]  STATE_D3       = `PM_STATE_D3;
  localparam [1:0]  STATE_RESET    = `PM_STATE_RESET;
  localparam [3:0]  PULSE_CYCLES   = `PM_RESET_PULSE_CYC;
  localparam [3:0]  PULSE_IDLE     = 4'h0;
  localparam [3:0]  PULSE_STEP     = 4'h1;
  localparam [2:0]  SYNC_RESET     = `PM_SYNC_RESET;
  localparam [0:0]  STRAP_RESET    = `PM_STRAP_RESET;
  localparam [0:0]  CLK_RUN_RESET  = `PM_CLK_RUN_RESET;
  localparam [0:0]  PULSE_RESET    = `PM_PULSE_RESET;
  localparam [31:0] READ_RESET     = `PM_READ_RESET;
  localparam [5:0]  RESERVED_VALUE = `PM_RESERVED_VALUE;
  localparam [3:0]  DSEL_VALUE     = `PM_DSEL_VALUE;
  localparam [1:0]  DSCALE_VALUE   = `PM_DSCALE_VALUE;
  localparam [7:0]  DATA_VALUE     = `PM_DATA_VALUE;

  // Widths
  localparam        LANES          = 4;
  localparam        LANE_WIDTH     = 8;
  localparam        DWORD_WIDTH    = 32;
  localparam        STATE_WIDTH    = 2;
  localparam        COUNT_WIDTH    = 4;

  // ----------------------------------------------------------------------
  // Synchroniser and power state storage
  // ----------------------------------------------------------------------
  reg  [2:0]             strapSync_reg;
  reg                    strapLevel_reg;
  reg                    strapLevel_next;
  wire                   strapAgree;
  reg  [STATE_WIDTH-1:0] powerState_reg;
  reg  [STATE_WIDTH-1:0] powerState_next;
  wire [STATE_WIDTH-1:0] stateCode;
  reg                    resetStart;
  reg  [COUNT_WIDTH-1:0] resetCount_reg;
  reg  [COUNT_WIDTH-1:0] resetCount_next;
  reg                    chipReset_next;
  reg                    secClockRun_next;

  // ----------------------------------------------------------------------
  // Decode and read image
  // ----------------------------------------------------------------------
  wire                   hitDword;
  wire                   writeHit;
  wire                   readHit;
  wire [LANES-1:0]       laneOn;
  wire [DWORD_WIDTH-1:0] laneMask;
  wire                   wakeEnableBit;
  wire                   wakeStatusBit;
  wire [3:0]             dataSelectField;
  wire [1:0]             dataScaleField;
  wire [5:0]             reservedLow;
  wire [5:0]             reservedExt;
  wire                   clockStopBit;
  wire                   bpccEnableBit;
  wire [LANE_WIDTH-1:0]  dataByte;
  reg  [DWORD_WIDTH-1:0] readWord;
  reg  [DWORD_WIDTH-1:0] cfgReadData_next;

  // ----------------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------------
  // The first stage may go metastable; only the later two are compared
  assign strapAgree = (strapSync_reg[1] == strapSync_reg[2]);

  always @* begin
    strapLevel_next = strapLevel_reg;
    if (strapAgree)
      strapLevel_next = strapSync_reg[2];
    else
      strapLevel_next = strapLevel_reg;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapSync_reg  <= SYNC_RESET;
      strapLevel_reg <= STRAP_RESET;
    end else begin
      strapSync_reg  <= {strapSync_reg[1:0], clockCtrlStrap};
      strapLevel_reg <= strapLevel_next;
    end
  end

  // ----------------------------------------------------------------------
  // Address and byte lane decode
  // ----------------------------------------------------------------------
  assign hitDword = (cfgAddr[7:2] == DWORD_ADDR[7:2]);
  assign writeHit = cfgWrite && hitDword;
  assign readHit  = cfgRead && hitDword;

  // Byte enables are active low; lane n covers bits 8n+7 down to 8n
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : laneGen
      assign laneOn[lane]              = !byteEnable_n[lane];
      assign laneMask[8*lane+7:8*lane] = {LANE_WIDTH{laneOn[lane]}};
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Power state writes
  // ----------------------------------------------------------------------
  assign stateCode = cfgWriteData[`PM_STATE_MSB:`PM_STATE_LSB];

  always @* begin
    powerState_next = powerState_reg;
    // Only lane 0 carries a writable field; writes on other lanes change nothing
    if (writeHit && laneOn[0]) begin
      case (stateCode)
        STATE_D0: powerState_next = STATE_D0;
        STATE_D1: powerState_next = powerState_reg;
        STATE_D2: powerState_next = powerState_reg;
        STATE_D3: powerState_next = STATE_D3;
        default:  powerState_next = powerState_reg;
      endcase
    end else begin
      powerState_next = powerState_reg;
    end
  end

  always @* begin
    resetStart = 1'b0;
    case (powerState_reg)
      STATE_D0: resetStart = 1'b0;
      STATE_D3: resetStart = (powerState_next == STATE_D0);
      default:  resetStart = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Internal reset pulse
  // ----------------------------------------------------------------------
  always @* begin
    resetCount_next = resetCount_reg;
    if (resetStart)
      resetCount_next = PULSE_CYCLES;
    else if (resetCount_reg != PULSE_IDLE)
      resetCount_next = resetCount_reg - PULSE_STEP;
    else
      resetCount_next = PULSE_IDLE;
  end

  // This pulse never reaches the secondary bus reset pin, nor this block
  always @* begin
    chipReset_next = 1'b0;
    if (resetCount_next != PULSE_IDLE)
      chipReset_next = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Secondary clock control
  // ----------------------------------------------------------------------
  // Follows the next state so the clocks stop in the same cycle as the state
  always @* begin
    secClockRun_next = 1'b1;
    case (powerState_next)
      STATE_D0: secClockRun_next = 1'b1;
      STATE_D1: secClockRun_next = 1'b1;
      STATE_D2: secClockRun_next = 1'b1;
      STATE_D3: secClockRun_next = !strapLevel_reg;
      default:  secClockRun_next = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Power management control/status fields
  // ----------------------------------------------------------------------
  assign reservedLow     = RESERVED_VALUE;
  assign wakeEnableBit   = 1'b0;
  assign dataSelectField = DSEL_VALUE;
  assign dataScaleField  = DSCALE_VALUE;
  assign wakeStatusBit   = 1'b0;

  // ----------------------------------------------------------------------
  // Bridge support extension fields
  // ----------------------------------------------------------------------
  assign reservedExt   = RESERVED_VALUE;
  assign bpccEnableBit = strapLevel_reg;
  // Bit 22 is undefined with the strap low; copying the strap keeps it simple
  assign clockStopBit  = strapLevel_reg;

  // ----------------------------------------------------------------------
  // Data byte
  // ----------------------------------------------------------------------
  assign dataByte = DATA_VALUE;

  // ----------------------------------------------------------------------
  // Read data assembly
  // ----------------------------------------------------------------------
  always @* begin
    readWord = READ_RESET;
    readWord[`PM_STATE_MSB:`PM_STATE_LSB]   = powerState_reg;
    readWord[`PM_RSVLO_MSB:`PM_RSVLO_LSB]   = reservedLow;
    readWord[`PM_WAKE_EN_BIT]               = wakeEnableBit;
    readWord[`PM_DSEL_MSB:`PM_DSEL_LSB]     = dataSelectField;
    readWord[`PM_DSCALE_MSB:`PM_DSCALE_LSB] = dataScaleField;
    readWord[`PM_WAKE_STAT_BIT]             = wakeStatusBit;
    readWord[`PM_RSVEXT_MSB:`PM_RSVEXT_LSB] = reservedExt;
    readWord[`PM_CLKSTOP_BIT]               = clockStopBit;
    readWord[`PM_BPCC_BIT]                  = bpccEnableBit;
    readWord[`PM_DATA_MSB:`PM_DATA_LSB]     = dataByte;
  end

  // Lanes that are not enabled, and other addresses, read as zero
  always @* begin
    cfgReadData_next = READ_RESET;
    if (readHit)
      cfgReadData_next = readWord & laneMask;
    else
      cfgReadData_next = READ_RESET;
  end

  // ----------------------------------------------------------------------
  // Power state register
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerState_reg <= STATE_RESET;
    end else begin
      powerState_reg <= powerState_next;
    end
  end

  // ----------------------------------------------------------------------
  // Reset pulse counter
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCount_reg <= PULSE_IDLE;
    end else begin
      resetCount_reg <= resetCount_next;
    end
  end

  // ----------------------------------------------------------------------
  // Chip reset output
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chipReset <= PULSE_RESET;
    end else begin
      chipReset <= chipReset_next;
    end
  end

  // ----------------------------------------------------------------------
  // Secondary clock output
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      secClockRun <= CLK_RUN_RESET;
    end else begin
      secClockRun <= secClockRun_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read data output
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReadData <= READ_RESET;
    end else begin
      cfgReadData <= cfgReadData_next;
    end
  end

endmodule // pm_regs

/* File: pm_regs_monitor.sv */
// Port checks for the power management register dword
module pm_regs_monitor (
  input wire        core_clk,
  input wire        rst_n,
  input wire        cfgWrite,
  input wire        cfgRead,
  input wire [7:0]  cfgAddr,
  input wire [3:0]  byteEnable_n,
  input wire [31:0] cfgWriteData,
  input wire        clockCtrlStrap,
  input wire [31:0] cfgReadData,
  input wire        chipReset,
  input wire        secClockRun
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_RSV: assert property (cfgReadData[21:2] == 20'h0) else $error("rsv");
  AST_DAT: assert property (cfgReadData[31:24] == 8'h0) else $error("data");
  AST_B22: assert property (cfgReadData[23] |-> cfgReadData[22]) else $error("b22");
  AST_IDL: assert property (!$past(cfgRead) |-> !cfgReadData) else $error("idle");
  AST_LAN: assert property ($past(cfgRead && byteEnable_n[0]) |-> !cfgReadData[1:0]) else $error("lane");
  AST_PUL: assert property ($rose(chipReset) |-> chipReset[*4] ##1 !chipReset) else $error("pulse");
  AST_CAU: assert property ($rose(chipReset) |-> $past(cfgWrite && !cfgWriteData[1:0])) else $error("cause");
  AST_STP: assert property ($fell(secClockRun) |-> $past(cfgWrite && clockCtrlStrap)) else $error("stop");
  AST_RUN: assert property ($rose(secClockRun) |-> chipReset) else $error("run");
  cover property ($rose(chipReset));
  cover property ($fell(secClockRun));
  cover property (cfgRead ##1 cfgReadData[23]);
endmodule // pm_regs_monitor

/* File: cfg_master.sv */
// Configuration master model on the primary side
module cfg_master (
  input wire          core_clk,
  input wire   [31:0] cfgReadData,
  output logic        cfgWrite = 1'b0, cfgRead = 1'b0,
  output logic [7:0]  cfgAddr = 8'h0,
  output logic [3:0]  byteEnable_n = 4'hF,
  output logic [31:0] cfgWriteData = 32'h0);
  timeunit 1ns;
  timeprecision 1ns;
  task xfer(input w, input [7:0] a, input [3:0] b, input [31:0] d, output [31:0] q);
    @(posedge core_clk);
    {cfgWrite, cfgRead} <= {w, !w};
    cfgAddr <= a;
    byteEnable_n <= b;
    cfgWriteData <= d;
    @(posedge core_clk);
    {cfgWrite, cfgRead} <= 2'h0;
    // Released data shows the inverse so a stale value never passes
    cfgWriteData <= ~d;
    #1 q = cfgReadData;
  endtask
endmodule // cfg_master

/* File: tb.sv */
// Testbench for the power management register dword
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t got %h", $time, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst_n = 1'b0, strap = 1'b1, chipReset, secClockRun, wrS, rdS;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wd, rd, q;
  int          mismatches = 0, comparisons = 0;
  cfg_master mst_u (.core_clk(core_clk), .cfgReadData(rd), .cfgWrite(wrS), .cfgRead(rdS),
    .cfgAddr(addr), .byteEnable_n(be), .cfgWriteData(wd));
  pm_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .cfgWrite(wrS), .cfgRead(rdS),
    .cfgAddr(addr), .byteEnable_n(be), .cfgWriteData(wd), .clockCtrlStrap(strap),
    .cfgReadData(rd), .chipReset(chipReset), .secClockRun(secClockRun));
  initial forever #5 core_clk = ~core_clk;
  task finish_test;
    $display("checks %0d errors %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input [3:0] b, input [31:0] d);
    mst_u.xfer(1'b1, 8'hE0, b, d, q);
  endtask
  task chk(input [7:0] a, input [3:0] b, input [31:0] e);
    mst_u.xfer(1'b0, a, b, 32'h0, q);
    `CHK(q, e)
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(8'hE0, 4'h0, 32'h00C00000);
    wr(4'h0, 32'hFFFFFFFF);
    chk(8'hE0, 4'h0, 32'h00C00003);
    `CHK(secClockRun, 1'b0)
    for (int c = 1; c < 3; c++) wr(4'h0, c);
    chk(8'hE0, 4'h0, 32'h00C00003);
    wr(4'h1, 32'h0);
    chk(8'hE0, 4'hE, 32'h00000003);
    chk(8'hE0, 4'h1, 32'h00C00000);
    chk(8'hDC, 4'h0, 32'h0);
    wr(4'h0, 32'h0);
    @(posedge core_clk);
    #1;
    `CHK({chipReset, secClockRun}, 2'h3)
    chk(8'hE0, 4'h0, 32'h00C00000);
    @(posedge core_clk);
    #1;
    `CHK(chipReset, 1'b0)
    @(posedge core_clk) strap <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(4'h0, 32'h3);
    chk(8'hE0, 4'h0, 32'h00000003);
    `CHK(secClockRun, 1'b1)
    finish_test;
  end
endmodule // tb
bind pm_regs pm_regs_monitor mon_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .cfgWrite(cfgWrite),
  .cfgRead(cfgRead),
  .cfgAddr(cfgAddr),
  .byteEnable_n(byteEnable_n),
  .cfgWriteData(cfgWriteData),
  .clockCtrlStrap(clockCtrlStrap),
  .cfgReadData(cfgReadData),
  .chipReset(chipReset),
  .secClockRun(secClockRun)
);
